// ### gpib_device_end.sv
// instrument end: classifies bus bytes, routes commands, buffers device data
// What the two ends do
// - controller addresses first, then drops attention
// - data bytes pass whole, never decoded
// - printable codes recommended for device data
// - eighth bit travels on the top line
// - attention bytes are commands, never data
// - non-attention bytes are device data
// - route each command to its function
// - addressed commands need listen; universal always
`timescale 1ns/1ps
`default_nettype none

module gpib_rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic               in_valid,
    output logic                    in_ready,
    input  wire logic [WIDTH-1:0]   in_data,
    output logic                    out_valid,
    input  wire logic               out_ready,
    output logic [WIDTH-1:0]        out_data,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0]    cnt_q, cnt_d;
    logic             ov_q, ov_d;
    logic [WIDTH-1:0] od_q, od_d;
    logic             push, pop;

    // storage count excludes the output register
    always_comb begin
        in_ready = (cnt_q != DEPTH_C);
        push     = in_valid && in_ready;
        pop      = (cnt_q != '0) && (!ov_q || out_ready);
        mem_d    = mem_q;
        wr_d     = wr_q;
        rd_d     = rd_q;
        cnt_d    = cnt_q;
        ov_d     = ov_q && !out_ready;
        od_d     = od_q;
        if (push) begin
            mem_d[wr_q] = in_data;
            wr_d        = (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            od_d = mem_q[rd_q];
            ov_d = 1'b1;
            rd_d = (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
        end
        cnt_d = cnt_q + CW'(push) - CW'(pop);
    end

    // output register keeps the sink side glitch free
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            ov_q  <= 1'b0;
            od_q  <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            ov_q  <= ov_d;
            od_q  <= od_d;
        end
    end

    // entries need no reset, they are never read before written
    always_ff @(posedge clk) begin
        mem_q <= mem_d;
    end

    assign out_valid = ov_q;
    assign out_data  = od_q;
    assign count     = cnt_q;
endmodule

module gpib_device_end #(
    parameter logic [gpib_pkg::ADDR_W-1:0] MY_ADDR = 5'h0A,
    parameter int                          DEPTH   = gpib_pkg::FIFO_DEPTH
) (
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    gpib_link_if.dev_end                    link,
    output logic                            rx_valid,
    input  wire logic                       rx_ready,
    output logic [gpib_pkg::BYTE_W-1:0]     rx_data,
    output logic                            listening,
    output logic                            talking,
    output logic                            serial_poll,
    output logic                            remote,
    output logic                            lockout,
    output logic                            pp_enabled,
    output logic [3:0]                      pp_config,
    output logic                            clear_pulse,
    output logic                            trigger_pulse
);
    import gpib_pkg::*;

    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] ROOM_C = CW'(DEPTH-2);

    logic             take, push;
    logic [6:0]       code;
    logic [CW-1:0]    fcount;
    logic             rfd_q, rfd_d;
    logic             lsn_q, lsn_d, tlk_q, tlk_d, spe_q, spe_d;
    logic             rem_q, rem_d, llo_q, llo_d;
    logic             ppc_q, ppc_d, ppe_q, ppe_d;
    logic [3:0]       ppcfg_q, ppcfg_d;
    logic             clr_q, clr_d, trg_q, trg_d;

    assign take = link.dav && rfd_q;
    assign code = link.dio[6:0];

    assign push = take && !link.atn && lsn_q;

    gpib_rx_fifo #(
        .WIDTH     (BYTE_W),
        .DEPTH     (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_valid  (push),
        .in_ready  (),
        .in_data   (link.dio),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data),
        .count     (fcount)
    );

    // command decode and addressing state
    always_comb begin
        // two free slots, since ready lags the count by a cycle
        rfd_d   = (fcount <= ROOM_C);
        lsn_d   = lsn_q;
        tlk_d   = tlk_q;
        spe_d   = spe_q;
        rem_d   = rem_q;
        llo_d   = llo_q;
        ppc_d   = ppc_q;
        ppe_d   = ppe_q;
        ppcfg_d = ppcfg_q;
        clr_d   = 1'b0;
        trg_d   = 1'b0;
        if (take && link.atn) begin
            // a primary (non-secondary) byte ends a pending configure
            if (code[6:5] != 2'h3) begin
                ppc_d = 1'b0;
            end
            if (code == CMD_UNL) begin
                lsn_d = 1'b0;
            end else if (code == CMD_UNT) begin
                tlk_d = 1'b0;
            end else if (code[6:5] == GRP_LISTEN && code[4:0] == MY_ADDR) begin
                lsn_d = 1'b1;
                rem_d = link.ren;
            end else if (code[6:5] == GRP_TALK) begin
                tlk_d = (code[4:0] == MY_ADDR);
            end
            unique case (code)
                CMD_DCL: clr_d = 1'b1;
                CMD_LLO: llo_d = 1'b1;
                CMD_SPE: spe_d = 1'b1;
                CMD_SPD: spe_d = 1'b0;
                CMD_PPU: begin
                    ppe_d   = 1'b0;
                    ppcfg_d = PP_CFG_RST;
                end
                default: ;
            endcase
            if (lsn_q) begin
                unique case (code)
                    CMD_SDC: clr_d = 1'b1;
                    CMD_GET: trg_d = 1'b1;
                    CMD_GTL: rem_d = 1'b0;
                    CMD_PPC: ppc_d = 1'b1;
                    default: ;
                endcase
                if (ppc_q && code[6:4] == GRP_PPE) begin
                    ppe_d   = 1'b1;
                    ppcfg_d = code[3:0];
                end else if (ppc_q && code == CMD_PPD) begin
                    ppe_d   = 1'b0;
                end
            end
        end
        if (!link.ren) begin
            rem_d = 1'b0;
            llo_d = 1'b0;
        end
        // interface clear unaddresses everything
        if (link.ifc) begin
            lsn_d = 1'b0;
            tlk_d = 1'b0;
            spe_d = 1'b0;
            ppc_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rfd_q   <= 1'b0;
            lsn_q   <= 1'b0;
            tlk_q   <= 1'b0;
            spe_q   <= 1'b0;
            rem_q   <= 1'b0;
            llo_q   <= 1'b0;
            ppc_q   <= 1'b0;
            ppe_q   <= 1'b0;
            ppcfg_q <= PP_CFG_RST;
            clr_q   <= 1'b0;
            trg_q   <= 1'b0;
        end else begin
            rfd_q   <= rfd_d;
            lsn_q   <= lsn_d;
            tlk_q   <= tlk_d;
            spe_q   <= spe_d;
            rem_q   <= rem_d;
            llo_q   <= llo_d;
            ppc_q   <= ppc_d;
            ppe_q   <= ppe_d;
            ppcfg_q <= ppcfg_d;
            clr_q   <= clr_d;
            trg_q   <= trg_d;
        end
    end

    assign link.rfd      = rfd_q;
    assign listening     = lsn_q;
    assign talking       = tlk_q;
    assign serial_poll   = spe_q;
    assign remote        = rem_q;
    assign lockout       = llo_q;
    assign pp_enabled    = ppe_q;
    assign pp_config     = ppcfg_q;
    assign clear_pulse   = clr_q;
    assign trigger_pulse = trg_q;
endmodule
`default_nettype wire

// ### gpib_pkg.sv
// shared constants for the gpib message classifier ends
package gpib_pkg;
    localparam int          BYTE_W      = 8;
    localparam int          CMD_W       = 7;
    localparam int          ADDR_W      = 5;
    localparam int          FIFO_DEPTH  = 8;
    // interface command codes on dio[6:0] (iso 7-bit)
    localparam logic [6:0]  CMD_GTL     = 7'h01;
    localparam logic [6:0]  CMD_SDC     = 7'h04;
    localparam logic [6:0]  CMD_PPC     = 7'h05;
    localparam logic [6:0]  CMD_GET     = 7'h08;
    localparam logic [6:0]  CMD_LLO     = 7'h11;
    localparam logic [6:0]  CMD_DCL     = 7'h14;
    localparam logic [6:0]  CMD_PPU     = 7'h15;
    localparam logic [6:0]  CMD_SPE     = 7'h18;
    localparam logic [6:0]  CMD_SPD     = 7'h19;
    localparam logic [6:0]  CMD_UNL     = 7'h3F;
    localparam logic [6:0]  CMD_UNT     = 7'h5F;
    // address groups: top two bits select listen or talk group
    localparam logic [1:0]  GRP_LISTEN  = 2'h1;
    localparam logic [1:0]  GRP_TALK    = 2'h2;
    // secondary group 0x60..0x6F enables, 0x70 disables a poll reply
    localparam logic [2:0]  GRP_PPE     = 3'h6;
    localparam logic [6:0]  CMD_PPD     = 7'h70;
    // recommended printable range for device data
    localparam logic [7:0]  PRINT_LO    = 8'h20;
    localparam logic [7:0]  PRINT_HI    = 8'h5E;
    localparam logic [3:0]  PP_CFG_RST  = 4'h0;
endpackage

// ### gpib_link_if.sv
// link between the controller end and the instrument end
`timescale 1ns/1ps
`default_nettype none
interface gpib_link_if;
    logic                       atn;    // high = interface message byte
    logic                       ren;
    logic                       ifc;
    logic                       dav;    // byte on dio is valid
    logic [gpib_pkg::BYTE_W-1:0] dio;
    logic                       rfd;    // instrument ready for a byte

    modport ctrl_end (output atn, output ren, output ifc, output dav, output dio, input rfd);
    modport dev_end  (input atn, input ren, input ifc, input dav, input dio, output rfd);
endinterface
`default_nettype wire

// ### gpib_ctrl_end.sv
// controller end: sends command and data bytes with attention set accordingly
`timescale 1ns/1ps
`default_nettype none
module gpib_ctrl_end (
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    gpib_link_if.ctrl_end                   link,
    input  wire logic                       cmd_valid,
    output logic                            cmd_ready,
    input  wire logic                       cmd_atn,
    input  wire logic [gpib_pkg::BYTE_W-1:0] cmd_byte,
    input  wire logic                       ren_req,
    input  wire logic                       ifc_req,
    output logic                            refused,
    output logic                            nonprint
);
    import gpib_pkg::*;

    typedef enum logic {IDLE, DRIVE} ctrl_state_t;

    ctrl_state_t      st_q, st_d;
    logic             atn_q, atn_d, dav_q, dav_d, rdy_q, rdy_d;
    logic             ren_q, ifc_q;
    logic             adr_q, adr_d, ref_q, ref_d, np_q, np_d;
    logic [BYTE_W-1:0] dio_q, dio_d;
    logic             accept;

    assign accept = cmd_valid && rdy_q;

    // byte sequencer; attention only moves between bytes
    always_comb begin
        st_d  = st_q;
        atn_d = atn_q;
        dav_d = dav_q;
        rdy_d = rdy_q;
        dio_d = dio_q;
        adr_d = adr_q;
        ref_d = 1'b0;
        np_d  = 1'b0;
        unique case (st_q)
            IDLE: begin
                // ready rises on the first edge after reset and stays up while idle
                rdy_d = 1'b1;
                if (accept) begin
                    rdy_d = 1'b0;
                    // data refused until a listener is addressed
                    if (!cmd_atn && !adr_q) begin
                        ref_d = 1'b1;
                        rdy_d = 1'b1;
                    end else begin
                        atn_d = cmd_atn;
                        // byte sent unaltered, bit 8 on top line
                        dio_d = cmd_byte;
                        dav_d = 1'b1;
                        st_d  = DRIVE;
                        np_d  = !cmd_atn && (cmd_byte < PRINT_LO || cmd_byte > PRINT_HI);
                        if (cmd_atn && cmd_byte[6:0] == CMD_UNL) begin
                            adr_d = 1'b0;
                        end else if (cmd_atn && cmd_byte[6:5] == GRP_LISTEN) begin
                            adr_d = 1'b1;
                        end
                    end
                end
            end
            DRIVE: begin
                // hold until the instrument takes it
                if (link.rfd) begin
                    dav_d = 1'b0;
                    rdy_d = 1'b1;
                    st_d  = IDLE;
                end
            end
        endcase
        if (ifc_req) begin
            adr_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_q  <= IDLE;
            atn_q <= 1'b1;
            dav_q <= 1'b0;
            rdy_q <= 1'b0;
            dio_q <= '0;
            adr_q <= 1'b0;
            ref_q <= 1'b0;
            np_q  <= 1'b0;
            ren_q <= 1'b0;
            ifc_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            atn_q <= atn_d;
            dav_q <= dav_d;
            rdy_q <= rdy_d;
            dio_q <= dio_d;
            adr_q <= adr_d;
            ref_q <= ref_d;
            np_q  <= np_d;
            ren_q <= ren_req;
            ifc_q <= ifc_req;
        end
    end

    assign link.atn  = atn_q;
    assign link.dav  = dav_q;
    assign link.dio  = dio_q;
    assign link.ren  = ren_q;
    assign link.ifc  = ifc_q;
    assign cmd_ready = rdy_q;
    assign refused   = ref_q;
    assign nonprint  = np_q;
endmodule
`default_nettype wire

// ### gpib_message_classifier_asserts.sv
// link timing and command decode checks across both ends
`timescale 1ns/1ps
`default_nettype none
module gpib_message_classifier_asserts
    import gpib_pkg::*;
#(
    parameter logic [ADDR_W-1:0] MY_ADDR = 5'h0A
) (
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              atn,
    input wire logic              ifc,
    input wire logic              dav,
    input wire logic [BYTE_W-1:0] dio,
    input wire logic              rfd,
    input wire logic              listening,
    input wire logic              talking,
    input wire logic              rx_valid,
    input wire logic              clear_pulse,
    input wire logic              trigger_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // a byte moves only on the edge where both sides agree
    logic take;
    assign take = dav && rfd;

    // command byte taken from the bus
    sequence cmd_s(logic [6:0] code);
        take && atn && dio[6:0] == code;
    endsequence
    // clear is a single-cycle strobe, never a level
    sequence clear_once_s;
        clear_pulse ##1 !clear_pulse;
    endsequence

    byte_hold_a: assert property (dav && !rfd |=> dav && $stable(dio) && $stable(atn))
        else $error("byte or attention changed before take");
    valid_drop_a: assert property (take |=> !dav)
        else $error("valid not dropped after take");
    listen_set_a: assert property (cmd_s({GRP_LISTEN, MY_ADDR}) |=> listening)
        else $error("own listen address ignored");
    unlisten_a: assert property (cmd_s(CMD_UNL) |=> !listening)
        else $error("unlisten ignored");
    talk_set_a: assert property (cmd_s({GRP_TALK, MY_ADDR}) |=> talking)
        else $error("own talk address ignored");
    universal_clear_a: assert property (cmd_s(CMD_DCL) |=> clear_once_s)
        else $error("device clear pulse wrong");
    trigger_gated_a: assert property (cmd_s(CMD_GET) |=> trigger_pulse == $past(listening))
        else $error("trigger not gated by listen state");
    data_inert_a: assert property (take && !atn && !ifc |=>
        $stable(listening) && $stable(talking) && !clear_pulse && !trigger_pulse)
        else $error("data byte acted on as a command");
    data_stored_a: assert property (take && !atn && listening |-> ##[2:3] rx_valid)
        else $error("listened data byte not delivered");
endmodule
`default_nettype wire

// ### gpib_message_classifier_test.sv
// end-to-end bench: controller end drives the instrument end over the link
`timescale 1ns/1ps
`default_nettype none
module gpib_message_classifier_test;
    import gpib_pkg::*;
    localparam logic [4:0] MY_ADDR = 5'h0A;
    logic       clk = 0, reset_n = 0, cmd_valid = 0, cmd_atn = 0, rx_ready = 0;
    logic       ren_req = 1, ifc_req = 0;
    logic [7:0] cmd_byte = 8'h00;
    logic       cmd_ready, refused, nonprint, rx_valid, listening, talking, serial_poll;
    logic       remote, lockout, pp_enabled, clear_pulse, trigger_pulse;
    logic [7:0] rx_data;
    logic [3:0] pp_config;
    logic [9:0] status;
    int         fail_count = 0, comparisons = 0, cycles = 0;
    int         n_trig = 0, n_clr = 0, n_ref = 0, n_np = 0;
    // command bytes, expected status after each (bit4 only after disable)
    logic [7:0] cmds [16] = '{8'h08, 8'h2A, 8'h4A, 8'h11, 8'h18, 8'h19, 8'h05, 8'h63,
                              8'h05, 8'h70, 8'h15, 8'h01, 8'h08, 8'h04, 8'h14, 8'h5F};
    logic [9:0] exps [16] = '{10'h000, 10'h240, 10'h340, 10'h360, 10'h3E0, 10'h360,
                              10'h360, 10'h373, 10'h373, 10'h000, 10'h360, 10'h320,
                              10'h320, 10'h320, 10'h320, 10'h220};
    logic [7:0] data [8] = '{8'h00, 8'h20, 8'h5E, 8'hFF, 8'h80, 8'h41, 8'h7F, 8'h3A};

    assign status = {listening, talking, serial_poll, remote, lockout, pp_enabled, pp_config};

    gpib_link_if gpib_link_if_i ();
    gpib_ctrl_end gpib_ctrl_end_i (.clk(clk), .reset_n(reset_n), .link(gpib_link_if_i),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_atn(cmd_atn), .cmd_byte(cmd_byte),
        .ren_req(ren_req), .ifc_req(ifc_req), .refused(refused), .nonprint(nonprint));
    gpib_device_end #(.MY_ADDR(MY_ADDR), .DEPTH(FIFO_DEPTH)) gpib_device_end_i (.clk(clk),
        .reset_n(reset_n), .link(gpib_link_if_i), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data), .listening(listening), .talking(talking), .serial_poll(serial_poll),
        .remote(remote), .lockout(lockout), .pp_enabled(pp_enabled), .pp_config(pp_config),
        .clear_pulse(clear_pulse), .trigger_pulse(trigger_pulse));
    gpib_message_classifier_asserts #(.MY_ADDR(MY_ADDR)) gpib_message_classifier_asserts_i (
        .clk(clk), .reset_n(reset_n), .atn(gpib_link_if_i.atn), .ifc(gpib_link_if_i.ifc),
        .dav(gpib_link_if_i.dav), .dio(gpib_link_if_i.dio), .rfd(gpib_link_if_i.rfd),
        .listening(listening), .talking(talking), .rx_valid(rx_valid),
        .clear_pulse(clear_pulse), .trigger_pulse(trigger_pulse));

    always #4 clk = ~clk;

    task automatic stop_test();
        if (fail_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // pulse tallies and hang guard; run needs well under 2000 cycles
    always @(posedge clk) begin
        cycles++;
        n_trig += (trigger_pulse === 1'b1);
        n_clr += (clear_pulse === 1'b1);
        n_ref += (refused === 1'b1);
        n_np += (nonprint === 1'b1);
        if (cycles == 5000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until the edge that sees ready, then two edges for effects to land
    task automatic send(input logic atn, input logic [7:0] b);
        cmd_valid = 1;
        cmd_atn = atn;
        cmd_byte = b;
        while (cmd_ready !== 1'b1) begin @(posedge clk); #1; end
        @(posedge clk);
        #1;
        cmd_valid = 0;
        repeat (2) begin @(posedge clk); #1; end
    endtask

    task automatic recv(input logic [7:0] exp);
        while (rx_valid !== 1'b1) begin @(posedge clk); #1; end
        check("rx_data", {2'b00, rx_data}, {2'b00, exp});
        rx_ready = 1;
        @(posedge clk);
        #1;
        rx_ready = 0;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        #1;
        reset_n = 1;
        check("status", status, 10'h000);
        send(0, 8'h41);
        check("rx_valid", {9'h000, rx_valid}, 10'h000);
        foreach (cmds[i]) begin
            send(1, cmds[i]);
            check("status", status & ((cmds[i] == 8'h70) ? 10'h010 : 10'h3FF), exps[i]);
        end
        check("trigger", 10'(n_trig), 10'h001);
        check("rx_valid", {9'h000, rx_valid}, 10'h000);
        foreach (data[i]) send(0, data[i]);
        // one byte waits at the output, seven in storage hit the two-slot guard
        check("rfd", {9'h000, gpib_link_if_i.rfd}, 10'h000);
        foreach (data[i]) recv(data[i]);
        check("nonprint", 10'(n_np), 10'h004);
        send(1, 8'h3F);
        check("status", status, 10'h020);
        send(0, 8'h55);
        check("refused", 10'(n_ref), 10'h002);
        // another instrument listens, so the byte reaches an unaddressed device
        send(1, 8'h2B);
        send(0, 8'h55);
        check("rx_valid", {9'h000, rx_valid}, 10'h000);
        send(1, 8'h14);
        send(1, 8'h08);
        check("clear", 10'(n_clr), 10'h003);
        check("trigger", 10'(n_trig), 10'h001);
        ren_req = 0;
        repeat (3) begin @(posedge clk); #1; end
        check("status", status, 10'h000);
        send(1, 8'h2A);
        check("status", status, 10'h200);
        ifc_req = 1;
        repeat (3) begin @(posedge clk); #1; end
        ifc_req = 0;
        check("status", status, 10'h000);
        stop_test();
    end
endmodule
`default_nettype wire
